// *** port_pin_mux.sv ***
// Port C/D pin-function mux with port registers, bit ops and port A wake-up.
// Assumes an AHB-Lite master on sys_clk_i and pins synchronous to that clock.
//
// Overview of operation
// - Port C pin 3: 00 GPIO, 01 LCD 19, 10 touch key 12, 11 I2C data.
// - Port C pin 2: 00 GPIO, 01 LCD 18, 10 touch key 11, 11 I2C clock.
// - Port C pin 1: 00 GPIO, 01 LCD 17, 10 touch key 10, 11 serial transmit.
// - Port C pin 0: 00 GPIO, 01 LCD 16, 10 touch key 9, 11 serial rx/tx.
// - Port C pin 7: 00 GPIO/timer clock, 01 LCD 23, 10 key 16, 11 compact out.
// - Port C pin 6: 00 GPIO, 01 LCD 22, 10 key 15, 11 periodic timer out.
// - Port C pin 5: 00 GPIO/timer clock, 01 LCD 21, 10 key 14, 11 compact out inv.
// - Port C pin 4: 00 GPIO, 01 LCD 20, 10 key 13, 11 periodic out inverted.
// - Port D pins: 00/11 GPIO, 01 LCD 24/25, 10 timer1 out or its inverse.
// - Port D selector bits 7 to 4 read zero and ignore writes.
// - Source bits pick I2C data, I2C clock, serial rx pins; bit 7 reads zero.
// - Every reset sets all port data and direction bits to one.
// - Bit set or clear reads the whole port, changes one bit, writes back.
// - A falling edge on a wake-enabled port A pin wakes a sleeping device.
// - Wake-up is enabled per port A pin, in any combination.
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module port_pin_mux (
	input  wire logic        sys_clk_i,
	input  wire logic        rstn_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [7:0]  haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic [31:0]      hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// Pads
	input  wire logic [7:0]  port_a_in_i,
	output logic [7:0]       port_a_out_o,
	output logic [7:0]       port_a_oe_o,
	input  wire logic [7:0]  port_b_in_i,
	output logic [7:0]       port_b_out_o,
	output logic [7:0]       port_b_oe_o,
	input  wire logic [7:0]  port_c_in_i,
	output logic [7:0]       port_c_out_o,
	output logic [7:0]       port_c_oe_o,
	input  wire logic [1:0]  port_d_in_i,
	output logic [1:0]       port_d_out_o,
	output logic [1:0]       port_d_oe_o,
	// Peripheral side, index 0 is segment/common line 16
	input  wire logic [9:0]  lcd_seg_com_out_i,
	input  wire logic [9:0]  lcd_seg_com_oe_i,
	// Index 0 is touch key 9
	input  wire logic [7:0]  touch_key_out_i,
	input  wire logic [7:0]  touch_key_oe_i,
	input  wire logic        i2c_sda_out_i,
	input  wire logic        i2c_sda_oe_i,
	input  wire logic        i2c_scl_out_i,
	input  wire logic        i2c_scl_oe_i,
	input  wire logic        serial_tx_out_i,
	input  wire logic        serial_rxtx_out_i,
	input  wire logic        serial_rxtx_oe_i,
	input  wire logic        compact_timer0_out_i,
	input  wire logic        compact_timer1_out_i,
	input  wire logic        periodic_timer_out_i,
	output logic             i2c_sda_in_o,
	output logic             i2c_scl_in_o,
	output logic             serial_rx_in_o,
	output logic             periodic_timer_clk_in_o,
	output logic             compact_timer0_clk_in_o,
	output logic             compact_timer1_clk_in_o,
	// Power management
	input  wire logic        sleep_i,
	output logic             wake_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0]  portc_low_sel_reg, portc_low_sel_next;
	logic [7:0]  portc_high_sel_reg, portc_high_sel_next;
	logic [7:0]  portd_sel_reg, portd_sel_next;
	logic [7:0]  input_src_sel_reg, input_src_sel_next;
	logic [7:0]  wake_en_reg, wake_en_next;
	logic [7:0]  data_reg [4], data_next [4];
	logic [7:0]  dir_reg [4], dir_next [4];
	logic        wr_pend_reg, wr_pend_next;
	logic [7:0]  wr_addr_reg, wr_addr_next;
	logic [31:0] rdata_reg, rdata_next;

	logic [7:0]  pin_level [4];
	logic [7:0]  bit_mask;
	logic [7:0]  wd;
	logic [2:0]  op_target;
	logic        op_value;
	logic        addr_phase;
	logic [7:0]  portc_sel [8];
	logic [7:0]  pc_lcd_out, pc_lcd_oe;
	logic [7:0]  pc_alt3_out, pc_alt3_oe;
	logic [7:0]  pc_is_gpio;
	logic [1:0]  pd_is_gpio;
	logic [1:0]  ptimer_src, ctimer0_src;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Zero wait states; reads other than port data use next-state values, so a fresh write shows
	assign addr_phase  = hsel_i && htrans_i[pin_mux_pkg::HTRANS_ACTIVE_BIT] && hready_i;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = rdata_reg;
	assign wd          = hwdata_i[7:0];
	assign op_target   = wd[pin_mux_pkg::BIT_OP_TARGET_LSB +: 3];
	assign op_value    = wd[pin_mux_pkg::BIT_OP_VALUE_BIT];
	assign bit_mask    = 8'h01 << wd[pin_mux_pkg::BIT_OP_INDEX_LSB +: 3];

	// Port reads return pad levels; port D has only two pads
	always_comb begin
		pin_level[0] = port_a_in_i;
		pin_level[1] = port_b_in_i;
		pin_level[2] = port_c_in_i;
		pin_level[3] = {data_reg[3][7:2], port_d_in_i};
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_comb begin
		portc_low_sel_next  = portc_low_sel_reg;
		portc_high_sel_next = portc_high_sel_reg;
		portd_sel_next      = portd_sel_reg;
		input_src_sel_next  = input_src_sel_reg;
		wake_en_next        = wake_en_reg;
		data_next           = data_reg;
		dir_next            = dir_reg;
		wr_pend_next        = addr_phase && hwrite_i;
		wr_addr_next        = haddr_i;
		if (wr_pend_reg) begin
			case (wr_addr_reg)
				pin_mux_pkg::PORTC_LOW_SEL_OFS:  portc_low_sel_next = wd;
				pin_mux_pkg::PORTC_HIGH_SEL_OFS: portc_high_sel_next = wd;
				pin_mux_pkg::PORTD_SEL_OFS:      portd_sel_next = wd & pin_mux_pkg::PORTD_SEL_MASK;
				pin_mux_pkg::INPUT_SRC_SEL_OFS:  input_src_sel_next = wd & pin_mux_pkg::INPUT_SRC_MASK;
				pin_mux_pkg::WAKE_EN_OFS:        wake_en_next = wd;
				pin_mux_pkg::PORTA_DATA_OFS:     data_next[0] = wd;
				pin_mux_pkg::PORTA_DIR_OFS:      dir_next[0] = wd;
				pin_mux_pkg::PORTB_DATA_OFS:     data_next[1] = wd;
				pin_mux_pkg::PORTB_DIR_OFS:      dir_next[1] = wd;
				pin_mux_pkg::PORTC_DATA_OFS:     data_next[2] = wd;
				pin_mux_pkg::PORTC_DIR_OFS:      dir_next[2] = wd;
				pin_mux_pkg::PORTD_DATA_OFS:     data_next[3] = wd;
				pin_mux_pkg::PORTD_DIR_OFS:      dir_next[3] = wd;
				pin_mux_pkg::BIT_OP_OFS: begin
					// Data targets read pad levels, so inputs can disturb latches
					if (op_target[0]) begin
						dir_next[op_target[2:1]] = op_value ?
							(dir_reg[op_target[2:1]] | bit_mask) :
							(dir_reg[op_target[2:1]] & ~bit_mask);
					end else begin
						data_next[op_target[2:1]] = op_value ?
							(pin_level[op_target[2:1]] | bit_mask) :
							(pin_level[op_target[2:1]] & ~bit_mask);
					end
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		rdata_next = rdata_reg;
		if (addr_phase && !hwrite_i) begin
			rdata_next = 32'h0000_0000;
			case (haddr_i)
				pin_mux_pkg::PORTC_LOW_SEL_OFS:  rdata_next[7:0] = portc_low_sel_next;
				pin_mux_pkg::PORTC_HIGH_SEL_OFS: rdata_next[7:0] = portc_high_sel_next;
				pin_mux_pkg::PORTD_SEL_OFS:      rdata_next[7:0] = portd_sel_next;
				pin_mux_pkg::INPUT_SRC_SEL_OFS:  rdata_next[7:0] = input_src_sel_next;
				pin_mux_pkg::WAKE_EN_OFS:        rdata_next[7:0] = wake_en_next;
				pin_mux_pkg::PORTA_DATA_OFS:     rdata_next[7:0] = pin_level[0];
				pin_mux_pkg::PORTA_DIR_OFS:      rdata_next[7:0] = dir_next[0];
				pin_mux_pkg::PORTB_DATA_OFS:     rdata_next[7:0] = pin_level[1];
				pin_mux_pkg::PORTB_DIR_OFS:      rdata_next[7:0] = dir_next[1];
				pin_mux_pkg::PORTC_DATA_OFS:     rdata_next[7:0] = pin_level[2];
				pin_mux_pkg::PORTC_DIR_OFS:      rdata_next[7:0] = dir_next[2];
				pin_mux_pkg::PORTD_DATA_OFS:     rdata_next[7:0] = pin_level[3];
				pin_mux_pkg::PORTD_DIR_OFS:      rdata_next[7:0] = dir_next[3];
				pin_mux_pkg::PORTA_LATCH_OFS:    rdata_next[7:0] = data_next[0];
				default:                         rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Data and direction come up all ones: every pin an input
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			portc_low_sel_reg  <= pin_mux_pkg::SEL_RESET;
			portc_high_sel_reg <= pin_mux_pkg::SEL_RESET;
			portd_sel_reg      <= pin_mux_pkg::SEL_RESET;
			input_src_sel_reg  <= pin_mux_pkg::SEL_RESET;
			wake_en_reg        <= pin_mux_pkg::WAKE_EN_RESET;
			for (int i = 0; i < 4; i++) begin
				data_reg[i] <= pin_mux_pkg::PORT_RESET;
				dir_reg[i]  <= pin_mux_pkg::PORT_RESET;
			end
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			rdata_reg   <= 32'h0000_0000;
		end else begin
			portc_low_sel_reg  <= portc_low_sel_next;
			portc_high_sel_reg <= portc_high_sel_next;
			portd_sel_reg      <= portd_sel_next;
			input_src_sel_reg  <= input_src_sel_next;
			wake_en_reg        <= wake_en_next;
			data_reg           <= data_next;
			dir_reg            <= dir_next;
			wr_pend_reg        <= wr_pend_next;
			wr_addr_reg        <= wr_addr_next;
			rdata_reg          <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// Pad outputs
	// ----------------------------------------------------------------
	// Direction bit one means input; the latch drives once cleared
	assign port_a_out_o = data_reg[0];
	assign port_a_oe_o  = ~dir_reg[0];
	assign port_b_out_o = data_reg[1];
	assign port_b_oe_o  = ~dir_reg[1];

	// Port C function sources per pin
	always_comb begin
		portc_sel[0] = {6'h00, portc_low_sel_reg[1:0]};
		portc_sel[1] = {6'h00, portc_low_sel_reg[3:2]};
		portc_sel[2] = {6'h00, portc_low_sel_reg[5:4]};
		portc_sel[3] = {6'h00, portc_low_sel_reg[7:6]};
		portc_sel[4] = {6'h00, portc_high_sel_reg[1:0]};
		portc_sel[5] = {6'h00, portc_high_sel_reg[3:2]};
		portc_sel[6] = {6'h00, portc_high_sel_reg[5:4]};
		portc_sel[7] = {6'h00, portc_high_sel_reg[7:6]};
		pc_lcd_out   = lcd_seg_com_out_i[7:0];
		pc_lcd_oe    = lcd_seg_com_oe_i[7:0];
		// Code 11 functions, pin 7 downward
		pc_alt3_out = {compact_timer0_out_i, periodic_timer_out_i, ~compact_timer0_out_i,
			~periodic_timer_out_i, i2c_sda_out_i, i2c_scl_out_i, serial_tx_out_i,
			serial_rxtx_out_i};
		pc_alt3_oe  = {3'h7, 1'b1, i2c_sda_oe_i, i2c_scl_oe_i, 1'b1, serial_rxtx_oe_i};
	end

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_portc
			pin_function_cell #(.ALT3_IS_GPIO(1'b0)) u_cell (
				.sel_i      (portc_sel[g][1:0]),
				.gpio_out_i (data_reg[2][g]),
				.gpio_oe_i  (~dir_reg[2][g]),
				.lcd_out_i  (pc_lcd_out[g]),
				.lcd_oe_i   (pc_lcd_oe[g]),
				.alt2_out_i (touch_key_out_i[g]),
				.alt2_oe_i  (touch_key_oe_i[g]),
				.alt3_out_i (pc_alt3_out[g]),
				.alt3_oe_i  (pc_alt3_oe[g]),
				.pad_out_o  (port_c_out_o[g]),
				.pad_oe_o   (port_c_oe_o[g]),
				.is_gpio_o  (pc_is_gpio[g])
			);
		end
		// Port D folds code 11 back to plain I/O
		for (g = 0; g < 2; g++) begin : g_portd
			pin_function_cell #(.ALT3_IS_GPIO(1'b1)) u_cell (
				.sel_i      (portd_sel_reg[2*g +: 2]),
				.gpio_out_i (data_reg[3][g]),
				.gpio_oe_i  (~dir_reg[3][g]),
				.lcd_out_i  (lcd_seg_com_out_i[8+g]),
				.lcd_oe_i   (lcd_seg_com_oe_i[8+g]),
				.alt2_out_i (g == 0 ? compact_timer1_out_i : ~compact_timer1_out_i),
				.alt2_oe_i  (1'b1),
				.alt3_out_i (1'b0),
				.alt3_oe_i  (1'b0),
				.pad_out_o  (port_d_out_o[g]),
				.pad_oe_o   (port_d_oe_o[g]),
				.is_gpio_o  (pd_is_gpio[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Input-source selection
	// ----------------------------------------------------------------
	// Timer clock pins only feed the timer while left as plain I/O
	assign ptimer_src  = input_src_sel_reg[pin_mux_pkg::PTIMER_SRC_LSB +: 2];
	assign ctimer0_src = input_src_sel_reg[pin_mux_pkg::CTIMER0_SRC_LSB +: 2];

	always_comb begin
		i2c_sda_in_o   = input_src_sel_reg[pin_mux_pkg::I2C_DATA_SRC_BIT] ?
			port_c_in_i[3] : port_a_in_i[3];
		i2c_scl_in_o   = input_src_sel_reg[pin_mux_pkg::I2C_CLOCK_SRC_BIT] ?
			port_c_in_i[2] : port_a_in_i[7];
		serial_rx_in_o = input_src_sel_reg[pin_mux_pkg::SERIAL_RX_SRC_BIT] ?
			port_c_in_i[0] : port_a_in_i[3];
		case (ptimer_src)
			2'h1:    periodic_timer_clk_in_o = port_c_in_i[5] & pc_is_gpio[5];
			2'h2:    periodic_timer_clk_in_o = port_c_in_i[7] & pc_is_gpio[7];
			default: periodic_timer_clk_in_o = port_a_in_i[0];
		endcase
		case (ctimer0_src)
			2'h1:    compact_timer0_clk_in_o = port_a_in_i[1];
			2'h2:    compact_timer0_clk_in_o = port_b_in_i[7];
			default: compact_timer0_clk_in_o = port_a_in_i[4];
		endcase
		compact_timer1_clk_in_o = port_d_in_i[0] & pd_is_gpio[0];
	end

	// Falling-edge wake-up from port A
	port_wake_detect u_wake (
		.sys_clk_i   (sys_clk_i),
		.rstn_i      (rstn_i),
		.pin_level_i (port_a_in_i),
		.wake_en_i   (wake_en_reg),
		.sleep_i     (sleep_i),
		.wake_o      (wake_o)
	);

endmodule

// *** pin_mux_pkg.sv ***
// Constants of the port pin-function mux.
// Assumes a single 25 MHz system clock and an AHB-Lite register bus.
package pin_mux_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] PORTC_LOW_SEL_OFS  = 8'h00;
	localparam logic [7:0] PORTC_HIGH_SEL_OFS = 8'h04;
	localparam logic [7:0] PORTD_SEL_OFS      = 8'h08;
	localparam logic [7:0] INPUT_SRC_SEL_OFS  = 8'h0c;
	localparam logic [7:0] PORTA_DATA_OFS     = 8'h10;
	localparam logic [7:0] PORTA_DIR_OFS      = 8'h14;
	localparam logic [7:0] PORTB_DATA_OFS     = 8'h18;
	localparam logic [7:0] PORTB_DIR_OFS      = 8'h1c;
	localparam logic [7:0] PORTC_DATA_OFS     = 8'h20;
	localparam logic [7:0] PORTC_DIR_OFS      = 8'h24;
	localparam logic [7:0] PORTD_DATA_OFS     = 8'h28;
	localparam logic [7:0] PORTD_DIR_OFS      = 8'h2c;
	localparam logic [7:0] BIT_OP_OFS         = 8'h30;
	localparam logic [7:0] WAKE_EN_OFS        = 8'h34;
	localparam logic [7:0] PORTA_LATCH_OFS    = 8'h38;

	// ----------------------------------------------------------------
	// Reset values and write masks
	// ----------------------------------------------------------------
	localparam logic [7:0] SEL_RESET       = 8'h00;
	localparam logic [7:0] PORT_RESET      = 8'hff;
	localparam logic [7:0] WAKE_EN_RESET   = 8'h00;
	localparam logic [7:0] PORTD_SEL_MASK  = 8'h0f;
	localparam logic [7:0] INPUT_SRC_MASK  = 8'h7f;

	// Field positions
	localparam int I2C_DATA_SRC_BIT   = 6;
	localparam int I2C_CLOCK_SRC_BIT  = 5;
	localparam int SERIAL_RX_SRC_BIT  = 4;
	localparam int PTIMER_SRC_LSB     = 2;
	localparam int CTIMER0_SRC_LSB    = 0;
	localparam int BIT_OP_INDEX_LSB   = 0;
	localparam int BIT_OP_TARGET_LSB  = 3;
	localparam int BIT_OP_VALUE_BIT   = 6;

	// Pin function codes
	localparam logic [1:0] FUNC_GPIO = 2'h0;
	localparam logic [1:0] FUNC_LCD  = 2'h1;
	localparam logic [1:0] FUNC_ALT2 = 2'h2;
	localparam logic [1:0] FUNC_ALT3 = 2'h3;

	// AHB-Lite transfer type high bit marks NONSEQ or SEQ
	localparam int HTRANS_ACTIVE_BIT = 1;

endpackage

// *** pin_function_cell.sv ***
// One pad's function mux over four sources.
// Assumes the sources are all synchronous to the system clock.
`timescale 1ns/1ps
module pin_function_cell #(
	parameter bit ALT3_IS_GPIO = 1'b0
) (
	input  wire logic [1:0] sel_i,
	input  wire logic       gpio_out_i,
	input  wire logic       gpio_oe_i,
	input  wire logic       lcd_out_i,
	input  wire logic       lcd_oe_i,
	input  wire logic       alt2_out_i,
	input  wire logic       alt2_oe_i,
	input  wire logic       alt3_out_i,
	input  wire logic       alt3_oe_i,
	output logic            pad_out_o,
	output logic            pad_oe_o,
	output logic            is_gpio_o
);

	// ----------------------------------------------------------------
	// Source selection
	// ----------------------------------------------------------------
	// Some pins fold code 11 back onto plain I/O
	always_comb begin
		is_gpio_o = (sel_i == pin_mux_pkg::FUNC_GPIO) ||
			(ALT3_IS_GPIO && sel_i == pin_mux_pkg::FUNC_ALT3);
		case (is_gpio_o ? pin_mux_pkg::FUNC_GPIO : sel_i)
			pin_mux_pkg::FUNC_LCD:  {pad_out_o, pad_oe_o} = {lcd_out_i, lcd_oe_i};
			pin_mux_pkg::FUNC_ALT2: {pad_out_o, pad_oe_o} = {alt2_out_i, alt2_oe_i};
			pin_mux_pkg::FUNC_ALT3: {pad_out_o, pad_oe_o} = {alt3_out_i, alt3_oe_i};
			default:                {pad_out_o, pad_oe_o} = {gpio_out_i, gpio_oe_i};
		endcase
	end

endmodule

// *** port_wake_detect.sv ***
// Falling-edge wake detector for port A.
// Assumes pin levels are already synchronous to the system clock.
`timescale 1ns/1ps
module port_wake_detect (
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	input  wire logic [7:0] pin_level_i,
	input  wire logic [7:0] wake_en_i,
	input  wire logic       sleep_i,
	output logic            wake_o
);

	logic [7:0] prev_reg;
	logic [7:0] prev_next;
	logic       wake_reg;
	logic       wake_next;

	// ----------------------------------------------------------------
	// Edge detection
	// ----------------------------------------------------------------
	// Previous level resets high, so an input low out of reset reads as a falling edge
	always_comb begin
		prev_next = pin_level_i;
		wake_next = sleep_i && |(prev_reg & ~pin_level_i & wake_en_i);
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prev_reg <= pin_mux_pkg::PORT_RESET;
			wake_reg <= 1'b0;
		end else begin
			prev_reg <= prev_next;
			wake_reg <= wake_next;
		end
	end

	assign wake_o = wake_reg;

endmodule

// *** port_pin_mux_monitor.sv ***
// Checker of the pin-function mux, on its top-level ports.
// Assumes single-word AHB-Lite writes with hready tied high, one clock.
`timescale 1ns/1ps
module port_pin_mux_monitor (
	input logic        sys_clk_i, rstn_i, hsel_i, hwrite_i, hready_i, sleep_i, wake_o,
	input logic [1:0]  htrans_i, port_d_out_o,
	input logic [7:0]  haddr_i, port_a_in_i, port_b_in_i, port_c_in_i, port_c_out_o,
	input logic [31:0] hwdata_i,
	input logic [9:0]  lcd_seg_com_out_i,
	input logic [7:0]  touch_key_out_i,
	input logic        i2c_sda_out_i, serial_rxtx_out_i, compact_timer0_out_i,
	input logic        compact_timer1_out_i, periodic_timer_out_i, i2c_sda_in_o,
	input logic        compact_timer0_clk_in_o
);
	// ----------------------------------------------------------------
	// Shadow selectors, loaded as the write data phase ends
	// ----------------------------------------------------------------
	logic       wr_q;
	logic [7:0] ad_q, sl, sh, sd, si, we;
	// Own copy of the selectors, so a register that never updates is caught
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{wr_q, ad_q, sl, sh, sd, si, we} <= '0;
		end else begin
			wr_q <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
			ad_q <= haddr_i;
			if (wr_q && ad_q == 8'h00) sl <= hwdata_i[7:0];
			if (wr_q && ad_q == 8'h04) sh <= hwdata_i[7:0];
			if (wr_q && ad_q == 8'h08) sd <= hwdata_i[7:0];
			if (wr_q && ad_q == 8'h0c) si <= hwdata_i[7:0];
			if (wr_q && ad_q == 8'h34) we <= hwdata_i[7:0];
		end
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	// ----------------------------------------------------------------
	// Pad routing, input sources and wake-up
	// ----------------------------------------------------------------
	AST_PC3_SDA: assert property (sl[7:6] == 2'h3 |-> port_c_out_o[3] == i2c_sda_out_i)
		else $error("pc3 route");
	AST_PC2_LCD: assert property (sl[5:4] == 2'h1 |-> port_c_out_o[2] == lcd_seg_com_out_i[2])
		else $error("pc2 route");
	AST_PC1_KEY: assert property (sl[3:2] == 2'h2 |-> port_c_out_o[1] == touch_key_out_i[1])
		else $error("pc1 route");
	AST_PC0_RXTX: assert property (sl[1:0] == 2'h3 |-> port_c_out_o[0] == serial_rxtx_out_i)
		else $error("pc0 route");
	AST_PC5_INV: assert property (sh[3:2] == 2'h3 |-> port_c_out_o[5] == !compact_timer0_out_i)
		else $error("pc5 route");
	AST_PC4_INV: assert property (sh[1:0] == 2'h3 |-> port_c_out_o[4] != periodic_timer_out_i)
		else $error("pc4 route");
	AST_PD0_CT1: assert property (sd[1:0] == 2'h2 |-> port_d_out_o[0] == compact_timer1_out_i)
		else $error("pd0 route");
	AST_SDA_SRC: assert property (i2c_sda_in_o == (si[6] ? port_c_in_i[3] : port_a_in_i[3]))
		else $error("sda source");
	AST_CT0_SRC: assert property (si[1:0] == 2'h2 |-> compact_timer0_clk_in_o == port_b_in_i[7])
		else $error("ct0 source");
	AST_WAKE: assert property ($past(rstn_i) && sleep_i
		&& |(we & $past(port_a_in_i) & ~port_a_in_i) |=> wake_o) else $error("no wake pulse");
	cover property (wake_o);
	cover property (sl[7:6] == 2'h3);
	cover property (si[1:0] == 2'h2);
endmodule

// *** periph_model.sv ***
// Far-side model: on-chip peripherals and the pad levels of ports B to D.
// Assumes one clock; the scrambled state steps each cycle so stale values show.
`timescale 1ns/1ps
module periph_model (
	input  logic       sys_clk_i,
	output logic [9:0] lcd_seg_com_out_i, lcd_seg_com_oe_i,
	output logic [7:0] touch_key_out_i, touch_key_oe_i, port_b_in_i, port_c_in_i,
	output logic [1:0] port_d_in_i,
	output logic       i2c_sda_out_i, i2c_sda_oe_i, i2c_scl_out_i, i2c_scl_oe_i, serial_tx_out_i,
	output logic       serial_rxtx_out_i, serial_rxtx_oe_i, compact_timer0_out_i,
	output logic       compact_timer1_out_i, periodic_timer_out_i
);
	logic [63:0] st = 64'h1;
	// Scrambled state: no line holds still
	always @(posedge sys_clk_i) begin
		st <= st * 64'h5851f42d4c957f2d + 64'h1;
	end
	assign {lcd_seg_com_out_i, lcd_seg_com_oe_i, touch_key_out_i, touch_key_oe_i, port_b_in_i,
		port_c_in_i, port_d_in_i, i2c_sda_out_i, i2c_sda_oe_i, i2c_scl_out_i, i2c_scl_oe_i,
		serial_tx_out_i, serial_rxtx_out_i, serial_rxtx_oe_i, compact_timer0_out_i,
		compact_timer1_out_i, periodic_timer_out_i} = st;
endmodule

// *** port_pin_mux_bench.sv ***
// Self-checking bench for the port pin-function mux over AHB-Lite.
// Assumes the peripheral model drives all peripheral lines and pads B to D.
`timescale 1ns/1ps
module port_pin_mux_bench;
	logic        sys_clk_i = 0, rstn_i = 0, hsel_i = 0, hwrite_i = 0, sleep_i = 0, w;
	logic        hready_i, hreadyout_o, hresp_o, wake_o;
	logic [1:0]  htrans_i = 0, port_d_in_i, port_d_out_o, port_d_oe_o;
	logic [2:0]  hsize_i = 3'h2;
	logic [7:0]  haddr_i = 0, port_a_in_i = 0, port_a_out_o, port_a_oe_o, port_b_in_i, r, v;
	logic [7:0]  port_b_out_o, port_b_oe_o, port_c_in_i, port_c_out_o, port_c_oe_o;
	logic [7:0]  touch_key_out_i, touch_key_oe_i;
	logic [9:0]  lcd_seg_com_out_i, lcd_seg_com_oe_i;
	logic [31:0] hwdata_i = 0, hrdata_o, rv;
	logic        i2c_sda_out_i, i2c_sda_oe_i, i2c_scl_out_i, i2c_scl_oe_i, serial_tx_out_i;
	logic        serial_rxtx_out_i, serial_rxtx_oe_i, compact_timer0_out_i, compact_timer1_out_i;
	logic        periodic_timer_out_i, i2c_sda_in_o, i2c_scl_in_o, serial_rx_in_o;
	logic        periodic_timer_clk_in_o, compact_timer0_clk_in_o, compact_timer1_clk_in_o;
	int          mismatches = 0, compares = 0, i;
	assign hready_i = hreadyout_o;
	port_pin_mux i_dut (.*);
	periph_model i_far (.*);
	// ----------------------------------------------------------------
	// Bus cycle, compare and expectation helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// Each phase held until hready; read data taken at the second edge
	task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
		int n;
		{hsel_i, haddr_i, htrans_i, hwrite_i} <= {1'b1, a, 2'h2, wr};
		n = 0;
		do @(posedge sys_clk_i); while (hready_i !== 1'b1 && ++n < 20);
		{hsel_i, htrans_i, hwdata_i} <= {3'h0, 24'h0, d};
		n = 0;
		do @(posedge sys_clk_i); while (hready_i !== 1'b1 && ++n < 20);
		rv = hrdata_o;
	endtask
	function automatic logic [7:0] exp_pc(input logic [7:0] s, input logic [7:0] d);
		logic [7:0] e, t;
		for (int k = 0; k < 8; k++) begin
			case (s[(k % 4) * 2 +: 2])
				2'h0: t = d;
				2'h1: t = lcd_seg_com_out_i[7:0];
				2'h2: t = touch_key_out_i;
				default: t = {compact_timer0_out_i, periodic_timer_out_i, ~compact_timer0_out_i,
					~periodic_timer_out_i, i2c_sda_out_i, i2c_scl_out_i, serial_tx_out_i,
					serial_rxtx_out_i};
			endcase
			e[k] = t[k];
		end
		return e;
	endfunction
	function automatic logic [5:0] exp_src(input logic [7:0] s);
		logic p, t;
		p = s[3:2] == 2'h1 ? port_c_in_i[5] : s[3:2] == 2'h2 ? port_c_in_i[7] : port_a_in_i[0];
		t = s[1:0] == 2'h1 ? port_a_in_i[1] : s[1:0] == 2'h2 ? port_b_in_i[7] : port_a_in_i[4];
		return {s[6] ? port_c_in_i[3] : port_a_in_i[3], s[5] ? port_c_in_i[2] : port_a_in_i[7],
			s[4] ? port_c_in_i[0] : port_a_in_i[3], p, t, port_d_in_i[0]};
	endfunction
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	// Watchdog: the tests need a few hundred cycles
	initial begin
		repeat (5000) @(posedge sys_clk_i);
		mismatches++;
		final_report();
	end
	initial begin
		void'($urandom(34));
		repeat (3) @(posedge sys_clk_i);
		rstn_i <= 1;
		@(posedge sys_clk_i);
		// Reset values; data registers skipped since they read pad levels
		for (i = 0; i < 16; i++) begin
			if (!(i inside {4, 6, 8, 10})) begin
				bus(8'(i * 4), 0, 0);
				chk(rv, (i inside {5, 7, 9, 11, 14}) ? 32'hff : 32'h0, "reset read");
			end
		end
		chk({port_a_out_o, port_a_oe_o}, 16'hff00, "reset pads");
		bus(8'h14, 1, 0);
		@(negedge sys_clk_i);
		chk({port_a_out_o, port_a_oe_o}, 16'hffff, "outputs drive high");
		@(posedge sys_clk_i);
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			r = 8'($urandom);
			bus(8'h08, 1, r);
			bus(8'h08, 0, 0);
			chk(rv, {28'h0, r[3:0]}, "port d selector");
			bus(8'h0c, 1, r);
			bus(8'h0c, 0, 0);
			chk(rv, {25'h0, r[6:0]}, "source selector");
		end
		$display("test registers done");
		// Latches loaded before the pins become outputs
		r = 8'($urandom);
		bus(8'h20, 1, r);
		bus(8'h24, 1, 0);
		bus(8'h28, 1, r);
		bus(8'h2c, 1, 0);
		for (i = 0; i < 16; i++) begin
			v = i < 4 ? {4{i[1:0]}} : 8'($urandom);
			bus(8'h00, 1, v);
			bus(8'h04, 1, v);
			bus(8'h08, 1, v);
			@(negedge sys_clk_i);
			chk(port_c_out_o, exp_pc(v, r), "port c mux");
			w = v[1:0] == 2'h1 ? lcd_seg_com_out_i[8] : v[1:0] == 2'h2 ? compact_timer1_out_i : r[0];
			chk(port_d_out_o[0], w, "port d mux");
			@(posedge sys_clk_i);
		end
		$display("test pin mux done");
		bus(8'h04, 1, 0);
		bus(8'h08, 1, 0);
		for (i = 0; i < 12; i++) begin
			v = i < 4 ? {1'b0, {3{i[0]}}, i[1:0], i[1:0]} : 8'($urandom);
			bus(8'h0c, 1, v);
			port_a_in_i <= 8'($urandom);
			@(negedge sys_clk_i);
			chk({i2c_sda_in_o, i2c_scl_in_o, serial_rx_in_o, periodic_timer_clk_in_o,
				compact_timer0_clk_in_o, compact_timer1_clk_in_o}, exp_src(v), "sources");
			@(posedge sys_clk_i);
		end
		$display("test sources done");
		for (i = 0; i < 8; i++) begin
			r = 8'($urandom);
			bus(8'h14, 1, r);
			bus(8'h30, 1, {2'h0, 3'h1, i[2:0]});
			bus(8'h14, 0, 0);
			chk(rv, {24'h0, r & ~(8'h1 << i)}, "clear dir bit");
			bus(8'h30, 1, {2'h1, 3'h0, i[2:0]});
			@(negedge sys_clk_i);
			chk(port_a_out_o, port_a_in_i | (8'h1 << i), "set data bit");
			@(posedge sys_clk_i);
		end
		$display("test bit ops done");
		// Pins 0 and 2 may wake; a disabled pin and an awake device must not
		bus(8'h34, 1, 8'h05);
		for (i = 0; i < 3; i++) begin
			{port_a_in_i, sleep_i} <= {8'hff, i < 2};
			@(posedge sys_clk_i);
			port_a_in_i <= i == 1 ? 8'hfd : 8'hfb;
			w = 0;
			repeat (3) begin
				@(negedge sys_clk_i);
				w |= wake_o;
			end
			chk(w, i == 0, "wake");
			@(posedge sys_clk_i);
		end
		$display("test wake done");
		final_report();
	end
endmodule
bind port_pin_mux port_pin_mux_monitor i_mon (.*);
